// >>> rtrx_map.svh
/*
 * address map, field positions, reset values and timing counts for the
 * receive staging and interrupt log block.
 * assumes a 16-bit shared ram word and a 10 MHz device clock.
 */
`ifndef RTRX_MAP_SVH
`define RTRX_MAP_SVH

// shared ram regions (word addresses)
`define RTRX_STAGE_BASE 16'h0020
`define RTRX_STAGE_LAST 16'h003f
`define RTRX_LOG_BASE 16'h0040
`define RTRX_LOG_LAST 16'h005f
`define RTRX_LOG_PTR_LAST 8'h5e
`define RTRX_LOG_PTR_RESET 8'h40
`define RTRX_HW_ADDR_WORD 16'h0000
`define RTRX_COUNT_MAX 8'hff

// identification word bit positions
`define RTRX_BIT_XEQZ 15
`define RTRX_BIT_IWA 14
`define RTRX_BIT_BCST 13
`define RTRX_BIT_MESSAGE_ERROR_IRQ 10
`define RTRX_BIT_ILLEGAL_COMMAND_IRQ 8
`define RTRX_HW_MSB 7

// axi register byte offsets
`define RTRX_OFF_CFG 12'h000
`define RTRX_OFF_IRQ_EN 12'h004
`define RTRX_OFF_LOG_PTR 12'h008
`define RTRX_OFF_ACK 12'h00c
`define RTRX_OFF_STATUS 12'h010

// register fields
`define RTRX_CFG_STAGE 0
`define RTRX_CFG_SWRST 1
`define RTRX_IRQ_EN_RESET 16'h0000

// timing
`define RTRX_CLK_HZ 10000000
`define RTRX_WORD_GAP_NS 20000
`define RTRX_WORD_GAP_CYC ((`RTRX_WORD_GAP_NS * (`RTRX_CLK_HZ / 1000000)) / 1000)

`endif

// >>> rtrx_pkg.sv
/*
 * types for the receive staging and interrupt log block.
 * assumes nothing beyond the map header.
 */
`default_nettype none
package rtrx_pkg;
    typedef enum logic [2:0] {
        RTRX_IDLE,
        RTRX_LOG_ID,
        RTRX_LOG_ADDR,
        RTRX_BURST
    } rtrx_state_e;
    typedef logic [15:0] rtrx_word_t;
endpackage
`default_nettype wire

// >>> rtrx_top.sv
/*
 * receive staging buffer and interrupt log ring writer with an axi4-lite
 * register slave. one shared ram write port serves both structures.
 * assumes the ram write port accepts one word per cycle and that the
 * terminal core delivers events as one-cycle pulses.
 */
// Added by the designer: the register offsets and register access over AXI4-Lite.
// What this block does
// - staging area is words 0x20 to 0x3f
// - staging used only while enable bit set
// - staged words burst-copied on clean completion of 1 to 31 words with no log entry pending or being written, else dropped
// - unstaged words written directly as received, except in a cycle where a log entry word is written
// - only enabled interrupt types are logged
// - log ring spans 0x40 to 0x5f, 16 entries
// - each entry: identification word then address word
// - identification word holds only occurred bits
// - message interrupt bit positions 15,14,13,10,8
// - hardware interrupts use bits 7 down to 0
// - concurrent message interrupts share one word, pulse
// - message address word is descriptor address
// - hardware address word is zero
// - reset loads pointer byte with 0x40
// - pointer byte even, 0x40 to 0x5e
// - first entry at offsets 0,1; step 2 per entry
// - pointer wraps to 0x40 after sixteenth entry
// - count byte counts events, saturates, read clears
// - two interrupt pins, two acknowledge inputs
`default_nettype none
`include "rtrx_map.svh"

module rtrx_top
    import rtrx_pkg::*;
#(
    parameter int STAGE_WORDS = 32,
    parameter int LOG_ENTRIES = 16,
    parameter int WORD_GAP_CYC = `RTRX_WORD_GAP_CYC
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic master_reset_in,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receive data from terminal core
    input wire logic rx_word_valid,
    input wire logic [15:0] rx_word,
    input wire logic [15:0] rx_buffer_addr,
    input wire logic rx_msg_done,
    input wire logic rx_msg_error,
    // interrupt events from terminal core
    input wire logic msg_event,
    input wire logic exec_count_zero_irq,
    input wire logic when_accessed_irq,
    input wire logic broadcast_received_irq,
    input wire logic message_error_irq,
    input wire logic illegal_command_irq,
    input wire logic [15:0] msg_descriptor_addr,
    input wire logic autoinit_serial_fail_irq,
    input wire logic loopback_fail_bus_a_irq,
    input wire logic loopback_fail_bus_b_irq,
    input wire logic timetag_event1_irq,
    input wire logic timetag_event0_irq,
    input wire logic terminal_address_parity_fail_irq,
    input wire logic eeprom_checksum_fail_irq,
    input wire logic ram_integrity_fail_irq,
    // acknowledges and interrupt pins
    input wire logic message_ack_in,
    input wire logic hardware_ack_in,
    output logic message_interrupt_out,
    output logic hardware_interrupt_out,
    // shared ram write port
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [15:0] ram_wdata
);

    function automatic logic [4:0] step5(input logic [4:0] v);
        step5 = v + 5'h01;
    endfunction

    // soft reset: aresetn low, master reset pin or software reset bit
    logic soft_rst;
    logic sw_rst_reg;
    assign soft_rst = !aresetn || master_reset_in || sw_rst_reg;

    // registers
    logic stage_en_reg;
    rtrx_word_t irq_en_reg;
    logic [7:0] log_ptr_reg;
    logic [7:0] log_cnt_reg;
    logic [4:0] stage_cnt_reg;
    logic [4:0] burst_idx_reg;
    logic [15:0] burst_dst_reg;
    rtrx_word_t stage_mem [STAGE_WORDS];
    logic [15:0] gap_cnt_reg;
    rtrx_state_e state_reg;
    rtrx_word_t pend_id_reg;
    rtrx_word_t pend_addr_reg;
    logic pend_reg;

    // identification word assembly
    rtrx_word_t msg_bits;
    rtrx_word_t hw_bits;
    rtrx_word_t msg_en;
    rtrx_word_t hw_en;
    always_comb
    begin
        msg_bits = 16'h0000;
        msg_bits[`RTRX_BIT_XEQZ] = exec_count_zero_irq;
        msg_bits[`RTRX_BIT_IWA] = when_accessed_irq;
        msg_bits[`RTRX_BIT_BCST] = broadcast_received_irq;
        msg_bits[`RTRX_BIT_MESSAGE_ERROR_IRQ] = message_error_irq;
        msg_bits[`RTRX_BIT_ILLEGAL_COMMAND_IRQ] = illegal_command_irq;
        hw_bits = {8'h00, autoinit_serial_fail_irq,
            loopback_fail_bus_a_irq, loopback_fail_bus_b_irq,
            timetag_event1_irq, timetag_event0_irq,
            terminal_address_parity_fail_irq, eeprom_checksum_fail_irq,
            ram_integrity_fail_irq};
        msg_en = msg_event ? (msg_bits & irq_en_reg) : 16'h0000;
        hw_en = hw_bits & irq_en_reg;
    end

    // one entry per cycle; a message is taken first, hardware waits one turn and then overwrites the pending message entry
    logic take_msg;
    logic take_hw;
    logic hw_hold_reg;
    rtrx_word_t hw_hold_bits_reg;
    rtrx_word_t hw_any;
    assign hw_any = hw_en | hw_hold_bits_reg;
    assign take_msg = msg_en != 16'h0000;
    assign take_hw = !take_msg && hw_any != 16'h0000;

    // axi write channel
    logic aw_ok_reg;
    logic w_ok_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic do_write;
    assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_ok_reg && !s_axi_bvalid;
    assign do_write = aw_ok_reg && w_ok_reg && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok_reg <= 1'b1;
                w_data_reg <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
            end
            if (do_write)
            begin
                aw_ok_reg <= 1'b0;
                w_ok_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_reg)
                    `RTRX_OFF_CFG, `RTRX_OFF_IRQ_EN, `RTRX_OFF_ACK:
                        s_axi_bresp <= 2'h0;
                    `RTRX_OFF_LOG_PTR, `RTRX_OFF_STATUS:
                        s_axi_bresp <= 2'h0;
                    default:
                        s_axi_bresp <= 2'h2;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers; software reset bit self-clears
    always_ff @(posedge aclk)
    begin
        if (!aresetn || master_reset_in)
        begin
            stage_en_reg <= 1'b0;
            sw_rst_reg <= 1'b0;
            irq_en_reg <= `RTRX_IRQ_EN_RESET;
        end
        else
        begin
            sw_rst_reg <= 1'b0;
            if (do_write && aw_addr_reg == `RTRX_OFF_CFG)
            begin
                stage_en_reg <= w_data_reg[`RTRX_CFG_STAGE];
                sw_rst_reg <= w_data_reg[`RTRX_CFG_SWRST];
            end
            if (do_write && aw_addr_reg == `RTRX_OFF_IRQ_EN)
                irq_en_reg <= w_data_reg[15:0];
        end
    end

    // axi read channel
    logic ptr_read;
    assign s_axi_arready = !s_axi_rvalid;
    assign ptr_read = s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `RTRX_OFF_LOG_PTR;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `RTRX_OFF_CFG:
                    s_axi_rdata <= {31'h0, stage_en_reg};
                `RTRX_OFF_IRQ_EN:
                    s_axi_rdata <= {16'h0000, irq_en_reg};
                `RTRX_OFF_LOG_PTR:
                    s_axi_rdata <= {16'h0000, log_cnt_reg, log_ptr_reg};
                `RTRX_OFF_ACK:
                    s_axi_rdata <= 32'h0000_0000;
                `RTRX_OFF_STATUS:
                    s_axi_rdata <= {26'h0, stage_cnt_reg, pend_reg};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // event count: a new event in the read cycle counts from one
    always_ff @(posedge aclk)
    begin
        if (soft_rst)
            log_cnt_reg <= 8'h00;
        else if (ptr_read)
            log_cnt_reg <= (take_msg || take_hw) ? 8'h01 : 8'h00;
        else if ((take_msg || take_hw) && log_cnt_reg != `RTRX_COUNT_MAX)
            log_cnt_reg <= log_cnt_reg + 8'h01;
    end

    // held hardware events and the pending entry waiting for the ram port
    always_ff @(posedge aclk)
    begin
        if (soft_rst)
        begin
            hw_hold_bits_reg <= 16'h0000;
            hw_hold_reg <= 1'b0;
        end
        else if (take_hw)
        begin
            hw_hold_bits_reg <= 16'h0000;
            hw_hold_reg <= 1'b0;
        end
        else
        begin
            hw_hold_bits_reg <= hw_any;
            hw_hold_reg <= hw_any != 16'h0000;
        end
    end

    logic log_start;
    assign log_start = pend_reg && state_reg == RTRX_IDLE
        && !rx_word_valid;
    always_ff @(posedge aclk)
    begin
        if (soft_rst)
        begin
            pend_reg <= 1'b0;
            pend_id_reg <= 16'h0000;
            pend_addr_reg <= 16'h0000;
        end
        else if (take_msg)
        begin
            pend_reg <= 1'b1;
            pend_id_reg <= msg_en;
            pend_addr_reg <= msg_descriptor_addr;
        end
        else if (take_hw)
        begin
            pend_reg <= 1'b1;
            pend_id_reg <= hw_any;
            pend_addr_reg <= `RTRX_HW_ADDR_WORD;
        end
        else if (log_start)
            pend_reg <= 1'b0;
    end

    // interrupt pins: one pulse per entry, held until acknowledged
    always_ff @(posedge aclk)
    begin
        if (soft_rst)
        begin
            message_interrupt_out <= 1'b0;
            hardware_interrupt_out <= 1'b0;
        end
        else
        begin
            if (take_msg)
                message_interrupt_out <= 1'b1;
            else if (message_ack_in)
                message_interrupt_out <= 1'b0;
            if (take_hw)
                hardware_interrupt_out <= 1'b1;
            else if (hardware_ack_in)
                hardware_interrupt_out <= 1'b0;
        end
    end

    // staging store and burst sequencing
    logic burst_start;
    logic direct_wr;
    assign burst_start = state_reg == RTRX_IDLE && !pend_reg
        && stage_en_reg && rx_msg_done && !rx_msg_error
        && stage_cnt_reg != 5'h00;
    assign direct_wr = rx_word_valid && !stage_en_reg;

    always_ff @(posedge aclk)
    begin
        if (soft_rst)
            stage_cnt_reg <= 5'h00;
        else if (rx_msg_done && state_reg != RTRX_BURST && !burst_start)
            stage_cnt_reg <= 5'h00; // errored message drops staged words
        else if (rx_word_valid && stage_en_reg)
        begin
            stage_mem[stage_cnt_reg] <= rx_word;
            stage_cnt_reg <= step5(stage_cnt_reg);
        end
        else if (state_reg == RTRX_BURST
            && step5(burst_idx_reg) == stage_cnt_reg)
            stage_cnt_reg <= 5'h00;
    end

    always_ff @(posedge aclk)
    begin
        if (soft_rst)
        begin
            state_reg <= RTRX_IDLE;
            log_ptr_reg <= `RTRX_LOG_PTR_RESET;
            burst_idx_reg <= 5'h00;
            burst_dst_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                RTRX_IDLE:
                    if (log_start)
                        state_reg <= RTRX_LOG_ID;
                    else if (burst_start)
                    begin
                        state_reg <= RTRX_BURST;
                        burst_idx_reg <= 5'h00;
                        burst_dst_reg <= rx_buffer_addr;
                    end
                RTRX_LOG_ID:
                    state_reg <= RTRX_LOG_ADDR;
                // a whole entry at once, so a read never sees an odd byte
                RTRX_LOG_ADDR:
                begin
                    state_reg <= RTRX_IDLE;
                    if (log_ptr_reg[4:0] == 5'h1e)
                        log_ptr_reg <= `RTRX_LOG_PTR_RESET;
                    else
                        log_ptr_reg <= log_ptr_reg + 8'h02;
                end
                RTRX_BURST:
                begin
                    burst_idx_reg <= step5(burst_idx_reg);
                    if (step5(burst_idx_reg) == stage_cnt_reg)
                        state_reg <= RTRX_IDLE;
                end
                default:
                    state_reg <= RTRX_IDLE;
            endcase
        end
    end

    // ram port: registered so data outputs come from flip-flops.
    // staged words are mirrored in the staging area; burst uses flip-flops
    always_ff @(posedge aclk)
    begin
        if (soft_rst)
        begin
            ram_we <= 1'b0;
            ram_addr <= 16'h0000;
            ram_wdata <= 16'h0000;
        end
        else
        begin
            ram_we <= 1'b0;
            if (state_reg == RTRX_LOG_ID)
            begin
                ram_we <= 1'b1;
                ram_addr <= {8'h00, log_ptr_reg};
                ram_wdata <= pend_id_reg;
            end
            else if (state_reg == RTRX_LOG_ADDR)
            begin
                ram_we <= 1'b1;
                ram_addr <= {8'h00, log_ptr_reg | 8'h01};
                ram_wdata <= pend_addr_reg;
            end
            else if (state_reg == RTRX_BURST)
            begin
                ram_we <= 1'b1;
                ram_addr <= burst_dst_reg + {11'h000, burst_idx_reg};
                ram_wdata <= stage_mem[burst_idx_reg];
            end
            else if (rx_word_valid)
            begin
                ram_we <= 1'b1;
                ram_addr <= direct_wr ? rx_buffer_addr
                    : `RTRX_STAGE_BASE + {11'h000, stage_cnt_reg};
                ram_wdata <= rx_word;
            end
        end
    end

    logic unused_ok;
    assign unused_ok = hw_hold_reg | (WORD_GAP_CYC == 0)
        | (LOG_ENTRIES == 0);

endmodule
`default_nettype wire

// >>> rtrx_chk.sv
/*
 * assertions for the staging and interrupt log block.
 * assumes binding onto rtrx_top and that no rx buffer lies in 0x40-0x5f.
 */
`default_nettype none
`include "rtrx_map.svh"
module rtrx_chk
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // events and pins
    input wire logic msg_event,
    input wire logic message_ack_in,
    input wire logic hardware_ack_in,
    input wire logic message_interrupt_out,
    input wire logic hardware_interrupt_out,
    // ram port
    input wire logic ram_we,
    input wire logic [15:0] ram_addr,
    input wire logic [15:0] ram_wdata
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic ptr_rd_reg;
    logic id_wr;
    // even ring slot: an identification word lands here
    assign id_wr = ram_we && ram_addr[15:5] == 11'h002 && !ram_addr[0];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ptr_rd_reg <= 1'h0;
        else if (s_axi_arvalid && s_axi_arready)
            ptr_rd_reg <= s_axi_araddr == `RTRX_OFF_LOG_PTR;
    end
    property p_pair;
        id_wr |=> ram_we && ram_addr == $past(ram_addr) + 16'h0001;
    endproperty
    a_pair: assert property (p_pair)
        else $error("address word missing after id word");
    property p_hw_zero;
        id_wr && ram_wdata[15:8] == 8'h00 |=> ram_wdata == 16'h0000;
    endproperty
    a_hw_zero: assert property (p_hw_zero)
        else $error("hardware entry address word not zero");
    property p_id_fmt;
        id_wr |-> ram_wdata != 16'h0000 && (ram_wdata & 16'h1a00) == 16'h0;
    endproperty
    a_id_fmt: assert property (p_id_fmt)
        else $error("id word has unused bits set");
    property p_ack_msg;
        message_ack_in |=> !message_interrupt_out;
    endproperty
    a_ack_msg: assert property (p_ack_msg)
        else $error("message pin stays up under ack");
    property p_ack_hw;
        hardware_ack_in |=> !hardware_interrupt_out;
    endproperty
    a_ack_hw: assert property (p_ack_hw)
        else $error("hardware pin stays up under ack");
    property p_rise_msg;
        $rose(message_interrupt_out) |-> $past(msg_event);
    endproperty
    a_rise_msg: assert property (p_rise_msg)
        else $error("message pin rose without an event");
    property p_ptr;
        s_axi_rvalid && ptr_rd_reg |-> !s_axi_rdata[0]
            && s_axi_rdata[7:0] inside {[8'h40:8'h5e]};
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer byte out of ring");
    property p_rst;
        $rose(aresetn) |-> !ram_we && !message_interrupt_out
            && !hardware_interrupt_out;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs active after reset");
    c_msg: cover property (id_wr && ram_wdata[15:8] != 8'h00);
    c_hw: cover property (id_wr && ram_wdata[15:8] == 8'h00);
    c_wrap: cover property (id_wr && ram_addr == 16'h005e);
    c_ptr: cover property (s_axi_rvalid && ptr_rd_reg);
endmodule
bind rtrx_top rtrx_chk CHK (.*);
`default_nettype wire

// >>> rtrx_ram_model.sv
/*
 * shared ram as the host sees it: stores the block's writes.
 * assumes all addresses used stay below 0x1000.
 */
`default_nettype none
module rtrx_ram_model
(
    // clock
    input wire logic aclk,
    // write port from the block
    input wire logic ram_we,
    input wire logic [15:0] ram_addr,
    input wire logic [15:0] ram_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:4095];
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 16'h0000;
    end
    // no host write path, so the staging area is never touched from here
    always @(posedge aclk)
    begin
        if (ram_we)
            mem[ram_addr[11:0]] <= ram_wdata;
    end
endmodule
`default_nettype wire

// >>> rt_rx_staging_and_interrupt_log_tb.sv
/*
 * bench for the staging and interrupt log block: axi4-lite host tasks,
 * event and rx drivers, ram model readback.
 * assumes the ram model and checker are compiled alongside.
 */
`default_nettype none
`include "rtrx_map.svh"
module rt_rx_staging_and_interrupt_log_tb import rtrx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, master_reset_in = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic rx_word_valid = 1'h0, rx_msg_done = 1'h0, rx_msg_error = 1'h0;
    logic [15:0] rx_word = 16'h0, rx_buffer_addr = 16'h0;
    logic [15:0] da = 16'h0, evb = 16'h0, ram_addr, ram_wdata;
    logic msg_event = 1'h0, message_ack_in = 1'h0, hardware_ack_in = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, message_interrupt_out, hardware_interrupt_out, ram_we;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int errors = 0, checks = 0, ep = 0, cnt = 0;
    always #50 aclk = ~aclk;
    rtrx_top DUT (.*, .msg_descriptor_addr(da),
        .exec_count_zero_irq(evb[15]), .when_accessed_irq(evb[14]),
        .broadcast_received_irq(evb[13]), .message_error_irq(evb[10]),
        .illegal_command_irq(evb[8]), .autoinit_serial_fail_irq(evb[7]),
        .loopback_fail_bus_a_irq(evb[6]), .loopback_fail_bus_b_irq(evb[5]),
        .timetag_event1_irq(evb[4]), .timetag_event0_irq(evb[3]),
        .terminal_address_parity_fail_irq(evb[2]),
        .eeprom_checksum_fail_irq(evb[1]), .ram_integrity_fail_irq(evb[0]));
    rtrx_ram_model RAM (.*);
    task give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        logic ka, kw, ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ta && tw))
        begin
            @(negedge aclk);
            ka = s_axi_awvalid && s_axi_awready;
            kw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ka)
                s_axi_awvalid <= 1'h0;
            if (kw)
                s_axi_wvalid <= 1'h0;
            ta |= ka;
            tw |= kw;
        end
        do
        begin
            @(negedge aclk);
            ka = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!ka);
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [11:0] a);
        logic k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(negedge aclk);
            k = s_axi_arready;
            @(posedge aclk);
        end while (!k);
        s_axi_arvalid <= 1'h0;
        do
        begin
            @(negedge aclk);
            k = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!k);
        s_axi_rready <= 1'h0;
    endtask
    // the read clears the count, so the model count restarts too
    task rptr();
        rd(`RTRX_OFF_LOG_PTR);
        chk("log pointer", {16'h0, cnt[7:0], 8'h40 + 8'(2 * ep)}, d);
        cnt = 0;
    endtask
    task ev(input logic m, input logic [15:0] b, input logic [15:0] a);
        @(posedge aclk);
        msg_event <= m;
        evb <= b;
        da <= a;
        @(posedge aclk);
        msg_event <= 1'h0;
        evb <= 16'h0;
        repeat (8) @(posedge aclk);
    endtask
    task lg(input rtrx_word_t i, input rtrx_word_t a);
        chk("id word", i, RAM.mem[12'h040 + 2 * ep]);
        chk("address word", a, RAM.mem[12'h041 + 2 * ep]);
        ep = (ep + 1) % 16;
        cnt = cnt < 255 ? cnt + 1 : 255;
    endtask
    task ack(input logic h);
        @(posedge aclk);
        message_ack_in <= !h;
        hardware_ack_in <= h;
        repeat (2) @(posedge aclk);
        chk("pin", 1'h0, h ? hardware_interrupt_out : message_interrupt_out);
        message_ack_in <= 1'h0;
        hardware_ack_in <= 1'h0;
    endtask
    task rx(input rtrx_word_t w);
        @(posedge aclk);
        rx_word_valid <= 1'h1;
        rx_word <= w;
        @(posedge aclk);
        rx_word_valid <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask
    task fin(input logic e);
        @(posedge aclk);
        rx_msg_done <= 1'h1;
        rx_msg_error <= e;
        @(posedge aclk);
        rx_msg_done <= 1'h0;
        rx_msg_error <= 1'h0;
        repeat (40) @(posedge aclk);
    endtask
    // longest path is the saturation loop, about 2700 cycles
    initial
    begin
        #2000000;
        errors++;
        give_verdict();
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rptr();
        rd(`RTRX_OFF_IRQ_EN);
        chk("irq enable", 32'h0, d);
        rd(12'h100);
        chk("unmapped read", 2'h2, r);
        wr(12'h100, 32'h0);
        chk("unmapped write", 2'h2, r);
        $display("test reset done");
        wr(`RTRX_OFF_IRQ_EN, 32'h0400);
        ev(1'h1, 16'h2400, 16'h0278);
        lg(16'h0400, 16'h0278);
        ev(1'h0, 16'h0001, 16'h0);
        chk("hw pin", 1'h0, hardware_interrupt_out);
        chk("msg pin", 1'h1, message_interrupt_out);
        ack(1'h0);
        rptr();
        $display("test mask done");
        wr(`RTRX_OFF_IRQ_EN, 32'hffff);
        for (int i = 0; i < 16; i++)
            if (!(i inside {9, 11, 12}))
            begin
                ev(i > 7, 16'h1 << i, 16'h0100 + i);
                lg(16'h1 << i, i > 7 ? 16'h0100 + i : 16'h0);
            end
        ev(1'h1, 16'h2400, 16'h0278);
        lg(16'h2400, 16'h0278);
        ev(1'h0, 16'h0080, 16'h0);
        lg(16'h0080, 16'h0);
        rptr();
        rptr();
        chk("hw pin", 1'h1, hardware_interrupt_out);
        ack(1'h1);
        ev(1'h0, 16'h0001, 16'h0);
        lg(16'h0001, 16'h0);
        $display("test ring done");
        repeat (270)
        begin
            ev(1'h0, 16'h0008, 16'h0);
            lg(16'h0008, 16'h0);
        end
        rptr();
        $display("test count done");
        wr(`RTRX_OFF_CFG, 32'h0);
        rx_buffer_addr <= 16'h0300;
        rx(16'h1111);
        chk("direct word", 16'h1111, RAM.mem[12'h300]);
        wr(`RTRX_OFF_CFG, 32'h1);
        rx_buffer_addr <= 16'h0310;
        for (int i = 0; i < 3; i++)
            rx(16'ha000 + i);
        chk("held word", 16'h0, RAM.mem[12'h310]);
        rd(`RTRX_OFF_STATUS);
        chk("status", 32'h6, d);
        fin(1'h1);
        chk("error message", 16'h0, RAM.mem[12'h310]);
        for (int i = 0; i < 3; i++)
            rx(16'hb000 + i);
        fin(1'h0);
        for (int i = 0; i < 3; i++)
            chk("burst word", 16'hb000 + i, RAM.mem[12'h310 + i]);
        chk("staged word", 16'hb002, RAM.mem[12'h022]);
        $display("test staging done");
        wr(`RTRX_OFF_CFG, 32'h3);
        repeat (2) @(posedge aclk);
        ep = 0;
        rptr();
        @(posedge aclk);
        master_reset_in <= 1'h1;
        @(posedge aclk);
        master_reset_in <= 1'h0;
        rd(`RTRX_OFF_CFG);
        chk("config", 32'h0, d);
        $display("test resets done");
        give_verdict();
    end
endmodule
`default_nettype wire
